// >>> hps_pkg.sv
// Purpose: constants for the host port and strap configuration block
// Assumes: AXI4-Lite register access, 32-bit data, one aligned word per register
// Notes: straps are low when the jumper is installed
package hps_pkg;

	// ==========================================================
	// register map
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
	localparam logic [ADDR_W-1:0] REG_STRAPS = 5'h04;
	localparam logic [ADDR_W-1:0] REG_COMMUT = 5'h08;
	localparam logic [ADDR_W-1:0] REG_MTYPE = 5'h0C;
	localparam logic [ADDR_W-1:0] REG_ISTAT = 5'h10;
	localparam logic [ADDR_W-1:0] REG_IMASK = 5'h14;
	localparam logic [ADDR_W-1:0] REG_AXES = 5'h18;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// field layout
	localparam int CTRL_SERVO_EN_BIT = 0;
	localparam int CTRL_MOTOR_OFF_BIT = 1;
	localparam int STR_BASE_LSB = 0;
	localparam int STR_MCLR_BIT = 10;
	localparam int STR_FWR_BIT = 11;
	localparam int STR_MOFF_BIT = 12;
	localparam int STR_DMA_BIT = 13;
	localparam int STR_IRQ_LSB = 16;
	localparam int STR_STEP_LSB = 24;
	localparam int AX_STD_LSB = 0;
	localparam int AX_PH2_LSB = 8;
	localparam int AX_AVAIL_LSB = 16;
	localparam int AX_STEP_LSB = 24;
	localparam int EV_MCLR = 0;
	localparam int EV_DRIVE = 1;
	localparam int EV_SELECT = 2;
	localparam int EV_W = 3;

	// ==========================================================
	// address decode and timing
	localparam int ADDR_STRAPS = 7;
	localparam int HOST_ADDR_W = 10;
	localparam int OFFSET_LSB = 2;
	localparam logic [HOST_ADDR_W-1:0] BASE_MIN = 10'h200;
	localparam logic [1:0] CAP_DLY = 2'h3;

endpackage : hps_pkg

// >>> hps_top.sv
// Purpose: host port decoder and power-up strap configuration
// Assumes: straps and host address come from pins; one clock at 125 MHz
// Notes: straps are caught after each reset release and then held
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module hps_top
	import hps_pkg::*;
#(
	parameter int NUM_AXES = 4,
	parameter int IRQ_SEL_W = 3
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [ADDR_STRAPS-1:0] address_strap_n,
	input wire logic master_clear_strap_n,
	input wire logic firmware_reload_strap_n,
	input wire logic motor_off_strap_n,
	input wire logic [NUM_AXES-1:0] stepper_select_strap_n,
	input wire logic dma_strap,
	input wire logic [IRQ_SEL_W-1:0] irq_strap,
	input wire logic [HOST_ADDR_W-1:0] host_addr,
	output logic card_select,
	output logic [1:0] reg_select,
	output logic master_clear,
	output logic firmware_reload_en,
	output logic drive_enable,
	output logic [NUM_AXES-1:0] step_dir_mode,
	output logic [NUM_AXES-1:0] dac_phase2,
	output logic [NUM_AXES-1:0] axis_avail,
	output logic dma_channel,
	output logic [(1<<IRQ_SEL_W)-1:0] host_irq_lines,
	output logic irq
);

	// ==========================================================
	// state
	localparam int PW = ADDR_STRAPS + 4 + NUM_AXES + IRQ_SEL_W + HOST_ADDR_W;
	localparam int CW = $clog2(NUM_AXES + 1);

	typedef struct packed {
		logic [PW-1:0] sync1;
		logic [PW-1:0] sync2;
		logic [1:0] cnt;
		logic done;
		logic [HOST_ADDR_W-1:0] base;
		logic mclr_inst;
		logic fwr_inst;
		logic moff_inst;
		logic [NUM_AXES-1:0] step_inst;
		logic dma_ch;
		logic [IRQ_SEL_W-1:0] irq_sel;
		logic card_sel;
		logic [1:0] reg_sel;
		logic mclr_pulse;
		logic drive_en;
		logic [NUM_AXES-1:0] commut;
		logic [NUM_AXES-1:0] mtype;
		logic [NUM_AXES-1:0] step_mode;
		logic [NUM_AXES-1:0] phase2;
		logic [NUM_AXES-1:0] avail;
		logic [CW-1:0] std_axes;
		logic [EV_W-1:0] istat;
		logic [EV_W-1:0] imask;
		logic irq;
		logic [(1<<IRQ_SEL_W)-1:0] host_irq;
		logic aw_ok;
		logic [ADDR_W-1:0] awaddr;
		logic w_ok;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} hps_state_t;

	hps_state_t q;
	hps_state_t d;
	logic wr_fire;
	logic servo_cmd;
	logic moff_cmd;

	// pin vector slices of the second synchroniser stage
	logic [ADDR_STRAPS-1:0] s_addr;
	logic s_mclr;
	logic s_fwr;
	logic s_moff;
	logic [NUM_AXES-1:0] s_step;
	logic s_dma;
	logic [IRQ_SEL_W-1:0] s_irq;
	logic [HOST_ADDR_W-1:0] s_host;

	assign {s_addr, s_mclr, s_fwr, s_moff, s_step, s_dma, s_irq, s_host} = q.sync2;
	assign wr_fire = q.aw_ok && q.w_ok && !q.bvalid;
	assign servo_cmd = wr_fire && q.awaddr == REG_CTRL && q.wstrb[0]
		&& q.wdata[CTRL_SERVO_EN_BIT];
	assign moff_cmd = wr_fire && q.awaddr == REG_CTRL && q.wstrb[0]
		&& q.wdata[CTRL_MOTOR_OFF_BIT];

	// ==========================================================
	// next state
	always_comb begin
		int ptr;
		int used;
		logic [EV_W-1:0] ev;
		logic [EV_W-1:0] clr;
		logic [31:0] rd;
		logic hit;
		ptr = NUM_AXES - 1;
		used = 0;
		ev = '0;
		clr = '0;
		rd = '0;
		hit = 1'b1;
		d = q;

		// two flops for every strap and host address pin before any logic reads it
		d.sync1 = {address_strap_n, master_clear_strap_n, firmware_reload_strap_n,
			motor_off_strap_n, stepper_select_strap_n, dma_strap, irq_strap, host_addr};
		d.sync2 = q.sync1;
		d.mclr_pulse = 1'b0;

		// straps are caught once the synchroniser has settled after reset
		if (!q.done) begin
			if (q.cnt == CAP_DLY) begin
				d.done = 1'b1;
				// an installed strap pulls its pin low and reads as a zero digit
				d.base = BASE_MIN + {1'b0, s_addr, 2'b00};
				d.mclr_inst = !s_mclr;
				d.mclr_pulse = !s_mclr;
				d.fwr_inst = !s_fwr;
				d.moff_inst = !s_moff;
				d.drive_en = s_moff;
				d.step_inst = ~s_step;
				d.dma_ch = s_dma;
				d.irq_sel = s_irq;
				ev[EV_MCLR] = !s_mclr;
				ev[EV_DRIVE] = s_moff;
			end else begin
				d.cnt = q.cnt + 2'h1;
			end
		end else begin
			d.card_sel = s_host[HOST_ADDR_W-1:OFFSET_LSB] == q.base[HOST_ADDR_W-1:OFFSET_LSB];
			d.reg_sel = s_host[1:0];
			ev[EV_SELECT] = d.card_sel && !q.card_sel;
			// motor-off wins when both commands arrive in one write
			if (moff_cmd) begin
				d.drive_en = 1'b0;
			end else if (servo_cmd) begin
				d.drive_en = 1'b1;
			end
			ev[EV_DRIVE] = d.drive_en != q.drive_en;
		end

		// dac routing: a commutated axis takes the highest free dac when that dac lies above the axis
		d.phase2 = '0;
		d.avail = '1;
		for (int i = 0; i < NUM_AXES; i++) begin
			if (q.commut[i] && i < ptr) begin
				d.phase2[ptr] = 1'b1;
				d.avail[ptr] = 1'b0;
				ptr = ptr - 1;
				used = used + 1;
			end
		end
		d.std_axes = CW'(NUM_AXES - used);
		d.step_mode = q.step_inst & q.mtype;

		// write channel
		if (s_axi_awvalid && q.awready) begin
			d.aw_ok = 1'b1;
			d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && q.wready) begin
			d.w_ok = 1'b1;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end
		if (wr_fire) begin
			d.aw_ok = 1'b0;
			d.w_ok = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = RESP_OKAY;
			unique case (q.awaddr)
				REG_CTRL, REG_STRAPS, REG_ISTAT, REG_AXES: begin
				end
				REG_COMMUT: if (q.wstrb[0]) d.commut = q.wdata[NUM_AXES-1:0];
				REG_MTYPE: if (q.wstrb[0]) d.mtype = q.wdata[NUM_AXES-1:0];
				REG_IMASK: if (q.wstrb[0]) d.imask = q.wdata[EV_W-1:0];
				default: d.bresp = RESP_SLVERR;
			endcase
		end else if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		d.awready = !d.aw_ok && !d.bvalid;
		d.wready = !d.w_ok && !d.bvalid;

		// read channel, answer on the same edge that takes the address
		if (s_axi_arvalid && q.arready) begin
			unique case (s_axi_araddr)
				REG_CTRL: rd = '0;
				REG_STRAPS: begin
					rd[STR_BASE_LSB +: HOST_ADDR_W] = q.base;
					rd[STR_MCLR_BIT] = q.mclr_inst;
					rd[STR_FWR_BIT] = q.fwr_inst;
					rd[STR_MOFF_BIT] = q.moff_inst;
					rd[STR_DMA_BIT] = q.dma_ch;
					rd[STR_IRQ_LSB +: IRQ_SEL_W] = q.irq_sel;
					rd[STR_STEP_LSB +: NUM_AXES] = q.step_inst;
				end
				REG_COMMUT: rd[NUM_AXES-1:0] = q.commut;
				REG_MTYPE: rd[NUM_AXES-1:0] = q.mtype;
				REG_ISTAT: begin
					rd[EV_W-1:0] = q.istat;
					clr = q.istat;
				end
				REG_IMASK: rd[EV_W-1:0] = q.imask;
				REG_AXES: begin
					rd[AX_STD_LSB +: CW] = q.std_axes;
					rd[AX_PH2_LSB +: NUM_AXES] = q.phase2;
					rd[AX_AVAIL_LSB +: NUM_AXES] = q.avail;
					rd[AX_STEP_LSB +: NUM_AXES] = q.step_mode;
				end
				default: hit = 1'b0;
			endcase
			d.rvalid = 1'b1;
			d.rdata = rd;
			d.rresp = hit ? RESP_OKAY : RESP_SLVERR;
		end else if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
		d.arready = !d.rvalid;

		// sticky events, a set in the clearing cycle survives
		d.istat = (q.istat & ~clr) | ev;
		d.irq = |(d.istat & d.imask);
		d.host_irq = '0;
		// only the strapped line is ever driven, so it is never shared
		if (d.irq) d.host_irq[d.irq_sel] = 1'b1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			// no dac is taken out of reset, so every axis reads as standard
			q.avail <= '1;
			q.std_axes <= CW'(NUM_AXES);
		end else if (clk_en) begin
			q <= d;
		end
	end

	// ==========================================================
	// outputs
	assign s_axi_awready = q.awready;
	assign s_axi_wready = q.wready;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign card_select = q.card_sel;
	assign reg_select = q.reg_sel;
	assign master_clear = q.mclr_pulse;
	assign firmware_reload_en = q.fwr_inst;
	assign drive_enable = q.drive_en;
	assign step_dir_mode = q.step_mode;
	assign dac_phase2 = q.phase2;
	assign axis_avail = q.avail;
	assign dma_channel = q.dma_ch;
	assign host_irq_lines = q.host_irq;
	assign irq = q.irq;

	// ==========================================================
	// checks
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn || !clk_en);

	a_base_from_straps: assert property (
		$rose(q.done) |-> q.base == BASE_MIN + {1'b0, $past(s_addr), 2'b00})
		else $error("base address not formed from straps");

	a_base_range_align: assert property (
		q.done |-> q.base[1:0] == 2'b00 && q.base >= BASE_MIN && q.base[HOST_ADDR_W-1])
		else $error("base address out of range or unaligned");

	a_card_select_match: assert property (
		q.done && $past(q.done) |-> q.card_sel == ($past(s_host[HOST_ADDR_W-1:OFFSET_LSB])
			== q.base[HOST_ADDR_W-1:OFFSET_LSB]))
		else $error("card select does not follow address match");

	a_master_clear_pulse: assert property (
		q.mclr_pulse |-> $rose(q.done) && q.mclr_inst ##1 !q.mclr_pulse)
		else $error("master clear pulse without installed strap");

	a_master_clear_given: assert property (
		$rose(q.done) && q.mclr_inst |-> q.mclr_pulse)
		else $error("master clear missing at power up");

	a_drive_power_up: assert property (
		$rose(q.done) |-> q.drive_en == !q.moff_inst)
		else $error("drive state at power up wrong");

	a_drive_held_off: assert property (
		q.done && !q.drive_en && !servo_cmd |=> !q.drive_en)
		else $error("drive enabled without servo command");

	a_drive_cmd_off: assert property (
		q.done && moff_cmd |=> !q.drive_en)
		else $error("motor off command ignored");

	a_std_axis_count: assert property (
		q.std_axes == CW'(NUM_AXES - $countones(q.phase2)) && (q.avail == ~q.phase2))
		else $error("standard axis count wrong");

	a_default_dacs: assert property (
		q.commut == '0 |=> q.phase2 == '0)
		else $error("dac reassigned without commutation");

	a_highest_dac: assert property (
		q.commut[0] |=> q.phase2[NUM_AXES-1])
		else $error("second phase not on highest dac");

	a_step_needs_both: assert property (
		q.step_mode != '0 |-> $past(q.step_inst & q.mtype) == q.step_mode)
		else $error("step mode without strap and command");

	a_irq_line_onehot: assert property (
		q.host_irq == (q.irq ? (1 << q.irq_sel) : 0))
		else $error("host interrupt line not the strapped one");

endmodule : hps_top

`default_nettype wire

// >>> hps_host_pc.sv
// Purpose: host bus side model driving the card address lines
// Assumes: one address cycle at a time, requested by the bench
// Notes: idle bus shows the inverse of the last address, not a held value
`timescale 1ns/1ps
`default_nettype none

module hps_host_pc (
	input wire logic aclk,
	input wire logic cyc,
	input wire logic [9:0] req_addr,
	output logic [9:0] host_addr
);
	// ==========================================================
	// address lines
	logic [9:0] last_q = 10'h000;

	always_ff @(posedge aclk) begin
		if (cyc) last_q <= req_addr;
	end
	// released bus must not look like a held address
	assign host_addr = cyc ? req_addr : ~last_q;
endmodule : hps_host_pc

`default_nettype wire

// >>> hps_top_tb.sv
// Purpose: self-checking bench for the host port and strap block
// Assumes: straps change only during reset
// Notes: random straps per reset, fixed seed
`timescale 1ns/1ps
`default_nettype none

module hps_top_tb;
	import hps_pkg::*;
	// ==========================================================
	// signals
	logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, cyc = 1'b0;
	logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0, irq_strap = '0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, dma_strap = 1'b0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd, rnd;
	logic [3:0] s_axi_wstrb = 4'hf, stepper_select_strap_n = '1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, reg_select, rsp;
	logic [6:0] address_strap_n = '1;
	logic master_clear_strap_n = 1'b1, firmware_reload_strap_n = 1'b1;
	logic motor_off_strap_n = 1'b1, card_select, master_clear, firmware_reload_en;
	logic drive_enable, dma_channel, irq;
	logic [3:0] step_dir_mode, dac_phase2, axis_avail, cm, mt, ph;
	logic [9:0] host_addr, req_addr = '0, base;
	logic [7:0] host_irq_lines;
	logic [31:0] seed = 32'h98f7_9dcc;
	int n_errors = 0, cmp_count = 0, cyc_cnt = 0, n_mc = 0;

	hps_top #(.NUM_AXES(4), .IRQ_SEL_W(3)) u_dut (.aclk, .aresetn, .clk_en,
		.s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .address_strap_n,
		.master_clear_strap_n, .firmware_reload_strap_n, .motor_off_strap_n,
		.stepper_select_strap_n, .dma_strap, .irq_strap, .host_addr, .card_select,
		.reg_select, .master_clear, .firmware_reload_en, .drive_enable, .step_dir_mode,
		.dac_phase2, .axis_avail, .dma_channel, .host_irq_lines, .irq);
	hps_host_pc u_host (.aclk, .cyc, .req_addr, .host_addr);

	initial forever #4 aclk = ~aclk;

	// ==========================================================
	// tasks
	task automatic complete_run();
		if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : complete_run

	always @(posedge aclk) begin
		cyc_cnt++;
		if (master_clear === 1'b1) n_mc++;
		if (cyc_cnt == 20000) begin
			n_errors++;
			complete_run();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rdr(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rdr

	// highest free dac, only above the axis itself
	function automatic logic [3:0] route(input logic [3:0] c);
		logic [3:0] p = '0;
		int hi;
		for (int a = 0; a < 4; a++) begin
			hi = 3;
			while (hi > 0 && p[hi]) hi--;
			if (c[a] && !p[hi] && hi > a) p[hi] = 1'b1;
		end
		return p;
	endfunction : route

	// ==========================================================
	// main sequence
	initial begin
		for (int it = 0; it < 4; it++) begin
			rnd = $random(seed);
			// corner cases: every address strap installed, then every one open
			if (it == 1) rnd[8:2] = '0;
			if (it == 2) rnd[8:2] = '1;
			aresetn <= 1'b0;
			{address_strap_n, master_clear_strap_n, firmware_reload_strap_n} <= rnd[8:0];
			{motor_off_strap_n, dma_strap, irq_strap} <= rnd[13:9];
			stepper_select_strap_n <= rnd[17:14];
			repeat (12) @(posedge aclk);
			aresetn <= 1'b1;
			n_mc = 0;
			repeat (8) @(posedge aclk);
			base = 10'h200 + {address_strap_n, 2'b00};
			chk(32'(n_mc), {31'h0, ~master_clear_strap_n});
			chk(32'({firmware_reload_en, dma_channel}), 32'({~firmware_reload_strap_n, dma_strap}));
			chk(32'(drive_enable), 32'(motor_off_strap_n));
			chk(32'({dac_phase2, axis_avail}), 32'h0f);
			rdr(REG_STRAPS, rd, rsp);
			chk(rd, {4'h0, ~stepper_select_strap_n, 5'h00, irq_strap, 2'h0, dma_strap,
				~motor_off_strap_n, ~firmware_reload_strap_n, ~master_clear_strap_n, base});
			// first four hit each register, the rest flip one decoded bit
			for (int k = 0; k < 12; k++) begin
				req_addr <= (k < 4) ? base | 10'(k) : base ^ (10'h001 << (k - 2));
				cyc <= 1'b1;
				repeat (4) @(posedge aclk);
				chk(32'({card_select, reg_select}), (k < 4) ? 32'(4 + k) : 32'h0);
			end
			// frozen clock enable: a matching address must not reach the decoder
			clk_en <= 1'b0;
			req_addr <= base;
			repeat (6) @(posedge aclk);
			chk(32'({card_select, drive_enable}), 32'({1'b0, motor_off_strap_n}));
			clk_en <= 1'b1;
			repeat (4) @(posedge aclk);
			chk(32'({card_select, reg_select}), 32'h4);
			cyc <= 1'b0;
			cm = rnd[21:18];
			mt = rnd[25:22];
			ph = route(cm);
			wr(REG_COMMUT, {28'h0, cm}, rsp);
			wr(REG_MTYPE, {28'h0, mt}, rsp);
			repeat (2) @(posedge aclk);
			chk(32'({dac_phase2, axis_avail, step_dir_mode}),
				32'({ph, ~ph, mt & ~stepper_select_strap_n}));
			rdr(REG_AXES, rd, rsp);
			chk(rd, {4'h0, mt & ~stepper_select_strap_n, 4'h0, ~ph, 4'h0, ph, 5'h00,
				3'(4 - $countones(ph))});
			rdr(REG_COMMUT, rd, rsp);
			chk(rd, {28'h0, cm});
			rdr(REG_ISTAT, rd, rsp);
			wr(REG_IMASK, 32'h0, rsp);
			wr(REG_CTRL, 32'h1, rsp);
			repeat (2) @(posedge aclk);
			chk(32'({drive_enable, irq}), 32'h2);
			wr(REG_IMASK, 32'h2, rsp);
			wr(REG_CTRL, 32'h2, rsp);
			repeat (2) @(posedge aclk);
			chk(32'({drive_enable, irq, host_irq_lines}), 32'({2'b01, 8'h01 << irq_strap}));
			rdr(REG_ISTAT, rd, rsp);
			chk(rd & 32'h2, 32'h2);
			repeat (2) @(posedge aclk);
			chk(32'({irq, host_irq_lines}), 32'h0);
			wr(5'h1c, 32'h0, rsp);
			chk(32'(rsp), 32'h2);
			rdr(5'h1c, rd, rsp);
			chk(rd | 32'(rsp), 32'h2);
		end
		complete_run();
	end
endmodule : hps_top_tb

`default_nettype wire
